/* common/adc_mux_pkg.sv */
// constants and types shared by the converter control ends
// Summary of operation
// [R1] select-and-convert clears flag, starts conversion
// [R2] conversion end sets the flag
// [R3] read-buffer: left-justified result, flag cleared
// [R4] flag-test skips when set; flag requests interrupt
// [R5] result word length six to eleven bits
// [R6] signed left-justified two's complement result
// [R7] zero volts 1000, minus ten 0111
// [R8] conversion time from length and accuracy
// [R9] six-bit channel select register, channels 0-63
// [R10] channel-select loads accumulator low six bits
// [R11] channel-index increments, top channel wraps
// [R12] only select-and-convert starts a conversion; here a rising edge on the convert pin also starts one
// [R13] sequential mode advances one, wraps to zero
// [R14] scan wraps early at last used channel
// [R15] individual mode connects addressed channel directly
// [R16] channel count multiple of four, max 64
// [R17] convert waits multiplexer settling after clear/index
// [R18] readin follows clear by one microsecond
// [R19] address inputs settled before clear
// [R20] address lines released before index pulse
// [R21] address lines: low level means asserted
// [R22] result buffer holds until next conversion
package adc_mux_pkg;
   localparam int IOT_W     = 18;
   localparam int ACC_W     = 18;
   localparam int CHAN_W    = 6;
   localparam int RES_W     = 11;
   localparam int WLEN_W    = 4;
   localparam int ACCSEL_W  = 2;
   localparam int CNT_W     = 16;
   localparam int WLEN_MIN  = 6;
   localparam int WLEN_MAX  = 11;
   localparam int MAX_CHANS = 64;
   localparam int CHAN_LSB  = 0;
   // instruction codes, octal 701304 701312 701301 701103 701201
   localparam logic [IOT_W-1:0] IOT_SEL_CONVERT = 18'h382C4;
   localparam logic [IOT_W-1:0] IOT_READ_BUF    = 18'h382CA;
   localparam logic [IOT_W-1:0] IOT_FLAG_TEST   = 18'h382C1;
   localparam logic [IOT_W-1:0] IOT_CHAN_SELECT = 18'h38243;
   localparam logic [IOT_W-1:0] IOT_CHAN_INDEX  = 18'h38281;
   // conversion time in microseconds, rows 0.8 0.2 0.1 0.05 percent
   localparam int CONV_US [4][6] = '{'{6, 7, 8, 9, 10, 11},
                                     '{10, 13, 14, 15, 17, 19},
                                     '{16, 19, 22, 24, 27, 29},
                                     '{25, 29, 33, 37, 41, 45}};
   localparam int CLK_PERIOD_NS   = 10;
   localparam int US_NS           = 1000;
   localparam int MUX_SETTLE_NS   = 2300;
   localparam int READIN_DELAY_NS = 1000;
   localparam int ADDR_SETUP_NS   = 1000;
   localparam int ADDR_RELEASE_NS = 2000;
   localparam int PIN_PULSE_NS    = 100;
   localparam int CONV_PULSE_NS   = 300;
   localparam int MUX_SETTLE_CYC   = (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READIN_DELAY_CYC = (READIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_SETUP_CYC   = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_RELEASE_CYC = (ADDR_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_PULSE_CYC    = (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_PULSE_CYC   = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      OP_SELECT, OP_INDEX, OP_CONVERT, OP_READ, OP_TEST,
      OP_PIN_LOAD, OP_PIN_INDEX, OP_PIN_CONVERT
   } host_op_e;
endpackage

/* common/adc_mux_if.sv */
// processor transfer bus and external address pins between the two ends
`timescale 1ns/10ps
`default_nettype none
interface adc_mux_if (
   input wire logic clk,
   input wire logic srst
);
   logic                            iotStrobe;
   logic [adc_mux_pkg::IOT_W-1:0]  iotCode;
   logic [adc_mux_pkg::ACC_W-1:0]  accToDev;
   logic [adc_mux_pkg::ACC_W-1:0]  accFromDev;
   logic                            accValid;
   logic                            skipReq;
   logic                            intReq;
   logic [adc_mux_pkg::CHAN_W-1:0] addrLineN;
   logic                            pinClear;
   logic                            pinReadin;
   logic                            pinIndex;
   logic                            pinConvert;
   modport host (
      input  clk, srst, accFromDev, accValid, skipReq, intReq,
      output iotStrobe, iotCode, accToDev, addrLineN,
      output pinClear, pinReadin, pinIndex, pinConvert
   );
   modport device (
      input  clk, srst, iotStrobe, iotCode, accToDev, addrLineN,
      input  pinClear, pinReadin, pinIndex, pinConvert,
      output accFromDev, accValid, skipReq, intReq
   );
endinterface
`default_nettype wire

/* design/adc_conv_timer.sv */
// conversion duration counter
`timescale 1ns/10ps
`default_nettype none
module adc_conv_timer #(
   parameter int CONV_SCALE_NS = adc_mux_pkg::US_NS
) (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            srst,
   // control
   input  wire logic                            start,
   input  wire logic [adc_mux_pkg::WLEN_W-1:0]  wordLen,
   input  wire logic [adc_mux_pkg::ACCSEL_W-1:0] accuracy,
   // status
   output logic                                 busy,
   output logic                                 done
);
   import adc_mux_pkg::*;
   int                convCycles;
   logic [CNT_W-1:0]  loadVal;
   logic [CNT_W-1:0]  cnt_ff;
   logic              busy_ff;
   logic              done_ff;

   always_comb begin
      convCycles = CONV_US[accuracy][int'(wordLen) - WLEN_MIN] * CONV_SCALE_NS / CLK_PERIOD_NS;
      if (convCycles < 1) begin
         convCycles = 1;
      end
   end
   assign loadVal = CNT_W'(convCycles - 1); // [R8]

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= busy_ff && !start && cnt_ff == '0;
         if (start) begin
            cnt_ff  <= loadVal;
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            cnt_ff  <= cnt_ff - CNT_W'(1);
            busy_ff <= cnt_ff != '0;
         end
      end
   end
   assign busy = busy_ff;
   assign done = done_ff;
endmodule
`default_nettype wire

/* design/adc_mux_device.sv */
// converter and multiplexer control, device end
`timescale 1ns/10ps
`default_nettype none
module adc_mux_device #(
   parameter int CHANNELS      = adc_mux_pkg::MAX_CHANS,
   parameter int CONV_SCALE_NS = adc_mux_pkg::US_NS
) (
   // processor side
   adc_mux_if.device                              bus,
   // front panel switches
   input  wire logic [adc_mux_pkg::WLEN_W-1:0]    panelWordLen,
   input  wire logic [adc_mux_pkg::ACCSEL_W-1:0]  panelAccuracy,
   input  wire logic [adc_mux_pkg::CHAN_W-1:0]    panelScanLast,
   // converter core
   input  wire logic [adc_mux_pkg::RES_W-1:0]     sampleLevel,
   // status
   output logic [adc_mux_pkg::CHAN_W-1:0]         muxChannel,
   output logic                                   convBusy,
   output logic                                   convFlag,
   output logic [adc_mux_pkg::RES_W-1:0]          resultBuf
);
   import adc_mux_pkg::*;

   localparam int PANEL_W = WLEN_W + ACCSEL_W + CHAN_W;
   localparam logic [CHAN_W-1:0] CHAN_TOP = CHAN_W'(CHANNELS - 1);
   localparam logic [WLEN_W-1:0] WL_MIN   = WLEN_W'(WLEN_MIN);
   localparam logic [WLEN_W-1:0] WL_MAX   = WLEN_W'(WLEN_MAX);

   logic                  clk;
   logic                  srst;
   logic [PANEL_W-1:0]    panelPins;
   logic [PANEL_W-1:0]    panelS1_ff;
   logic [PANEL_W-1:0]    panelS2_ff;
   logic [PANEL_W-1:0]    panelS3_ff;
   logic [PANEL_W-1:0]    panel_ff;
   logic [WLEN_W-1:0]     wlRaw;
   logic [ACCSEL_W-1:0]   accSel;
   logic [CHAN_W-1:0]     scanLast;
   logic [WLEN_W-1:0]     wlClamped;

   assign clk  = bus.clk;
   assign srst = bus.srst;

   //////////////////////////////////////////////////////////////////////////
   // front panel synchronisers
   assign panelPins = {panelWordLen, panelAccuracy, panelScanLast};

   genvar gi;
   generate
      for (gi = 0; gi < PANEL_W; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               panelS1_ff[gi] <= 1'b0;
               panelS2_ff[gi] <= 1'b0;
               panelS3_ff[gi] <= 1'b0;
               panel_ff[gi]   <= 1'b0;
            end else begin
               panelS1_ff[gi] <= panelPins[gi];
               panelS2_ff[gi] <= panelS1_ff[gi];
               panelS3_ff[gi] <= panelS2_ff[gi];
               if (panelS2_ff[gi] == panelS3_ff[gi]) begin
                  panel_ff[gi] <= panelS3_ff[gi];
               end
            end
         end
      end
   endgenerate

   assign wlRaw    = panel_ff[PANEL_W-1 -: WLEN_W];
   assign accSel   = panel_ff[CHAN_W +: ACCSEL_W];
   assign scanLast = panel_ff[CHAN_W-1:0];
   // word length limited to six through eleven
   assign wlClamped = (wlRaw < WL_MIN) ? WL_MIN :
                      (wlRaw > WL_MAX) ? WL_MAX : wlRaw; // [R5]

   //////////////////////////////////////////////////////////////////////////
   // instruction decode and pin edges
   logic cmdSelConv;
   logic cmdRead;
   logic cmdTest;
   logic cmdChanSel;
   logic cmdChanIdx;
   logic clearPrev_ff;
   logic readinPrev_ff;
   logic indexPrev_ff;
   logic convPrev_ff;
   logic clearRise;
   logic readinRise;
   logic indexRise;
   logic convRise;

   assign cmdSelConv = bus.iotStrobe && bus.iotCode == IOT_SEL_CONVERT;
   assign cmdRead    = bus.iotStrobe && bus.iotCode == IOT_READ_BUF;
   assign cmdTest    = bus.iotStrobe && bus.iotCode == IOT_FLAG_TEST;
   assign cmdChanSel = bus.iotStrobe && bus.iotCode == IOT_CHAN_SELECT;
   assign cmdChanIdx = bus.iotStrobe && bus.iotCode == IOT_CHAN_INDEX;

   assign clearRise  = bus.pinClear && !clearPrev_ff;
   assign readinRise = bus.pinReadin && !readinPrev_ff;
   assign indexRise  = bus.pinIndex && !indexPrev_ff;
   assign convRise   = bus.pinConvert && !convPrev_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         clearPrev_ff  <= 1'b0;
         readinPrev_ff <= 1'b0;
         indexPrev_ff  <= 1'b0;
         convPrev_ff   <= 1'b0;
      end else begin
         clearPrev_ff  <= bus.pinClear;
         readinPrev_ff <= bus.pinReadin;
         indexPrev_ff  <= bus.pinIndex;
         convPrev_ff   <= bus.pinConvert;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // channel select register
   logic [CHAN_W-1:0] chan_ff;
   logic [CHAN_W-1:0] nxt_chan;
   logic [CHAN_W-1:0] chanIndexed;
   logic [CHAN_W-1:0] addrAsserted;
   logic [CHAN_W-1:0] chanCleared;
   logic              scanWrap;

   // low level on an address line means asserted
   assign addrAsserted = ~bus.addrLineN; // [R21]
   assign scanWrap     = chan_ff >= scanLast || chan_ff == CHAN_TOP; // [R14] [R16]
   assign chanIndexed  = scanWrap ? '0 : chan_ff + CHAN_W'(1); // [R11] [R13]
   assign chanCleared  = clearRise ? '0 : chan_ff;

   always_comb begin
      nxt_chan = chan_ff;
      if (cmdChanSel) begin
         nxt_chan = bus.accToDev[CHAN_LSB +: CHAN_W]; // [R10]
      end else if (cmdChanIdx || indexRise) begin
         nxt_chan = chanIndexed; // [R11] [R13]
      end else if (readinRise) begin
         nxt_chan = chanCleared | addrAsserted; // [R15]
      end else if (clearRise) begin
         nxt_chan = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chan_ff <= '0;
      end else begin
         chan_ff <= nxt_chan; // [R9]
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // conversion and completion flag
   logic                convStart;
   logic                convDone;
   logic [WLEN_W-1:0]   wlHeld_ff;
   logic [RES_W-1:0]    codeOffset;
   logic [RES_W-1:0]    codeMask;
   logic [RES_W-1:0]    result_ff;
   logic                flag_ff;
   logic                nxt_flag;

   // channel loads never start a conversion
   assign convStart = cmdSelConv || convRise; // [R1] [R12]

   adc_conv_timer #(
      .CONV_SCALE_NS (CONV_SCALE_NS)
   ) u_timer (
      .clk      (clk),
      .srst     (srst),
      .start    (convStart),
      .wordLen  (wlClamped),
      .accuracy (accSel),
      .busy     (convBusy),
      .done     (convDone)
   );

   // msb inverted: 0 V gives 1000..., -5 V 0000..., -10 V 0111...
   assign codeOffset = {~sampleLevel[RES_W-1], sampleLevel[RES_W-2:0]}; // [R6] [R7]
   assign codeMask   = ~({RES_W{1'b1}} >> wlHeld_ff); // [R5]

   // completion wins over a clear in the same cycle
   always_comb begin
      nxt_flag = flag_ff;
      if (convDone) begin
         nxt_flag = 1'b1; // [R2]
      end else if (cmdSelConv || cmdRead) begin
         nxt_flag = 1'b0; // [R1] [R3]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wlHeld_ff <= WL_MIN;
         result_ff <= '0;
         flag_ff   <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         if (convStart) begin
            wlHeld_ff <= wlClamped;
         end
         if (convDone) begin
            result_ff <= codeOffset & codeMask; // [R22]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // answers to the processor
   logic [ACC_W-1:0] accOut_ff;
   logic             accValid_ff;
   logic             skip_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         accOut_ff   <= '0;
         accValid_ff <= 1'b0;
         skip_ff     <= 1'b0;
      end else begin
         accValid_ff <= cmdRead;
         skip_ff     <= cmdTest && flag_ff; // [R4]
         if (cmdRead) begin
            accOut_ff <= {result_ff, {(ACC_W-RES_W){1'b0}}}; // [R3] [R6]
         end
      end
   end

   assign bus.accFromDev = accOut_ff;
   assign bus.accValid   = accValid_ff;
   assign bus.skipReq    = skip_ff;
   assign bus.intReq     = flag_ff; // [R4]
   assign muxChannel     = chan_ff; // [R15]
   assign convFlag       = flag_ff;
   assign resultBuf      = result_ff;
endmodule
`default_nettype wire

/* design/adc_mux_host.sv */
// processor end: issues transfer instructions and drives the address pins
`timescale 1ns/10ps
`default_nettype none
module adc_mux_host (
   // device side
   adc_mux_if.host                          bus,
   // user requests
   input  wire logic                        reqValid,
   input  wire adc_mux_pkg::host_op_e       reqOp,
   input  wire logic [adc_mux_pkg::ACC_W-1:0] reqData,
   output logic                             reqReady,
   // user answers
   output logic                             rspValid,
   output logic [adc_mux_pkg::ACC_W-1:0]    rspData,
   output logic                             rspSkip
);
   import adc_mux_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE, H_IOT, H_ANS, H_SETUP, H_CLEAR, H_GAP, H_READIN,
      H_RELEASE, H_INDEX, H_SETTLE, H_CONVERT
   } host_state_e;

   logic               clk_w;
   host_state_e        state_ff;
   logic [CNT_W-1:0]   cnt_ff;
   logic [CNT_W-1:0]   settle_ff;
   logic [CNT_W-1:0]   release_ff;
   logic               strobe_ff;
   logic [IOT_W-1:0]   code_ff;
   logic [ACC_W-1:0]   acc_ff;
   logic [CHAN_W-1:0]  addrN_ff;
   logic               clear_ff;
   logic               readin_ff;
   logic               index_ff;
   logic               conv_ff;
   logic               ready_ff;
   logic               rspValid_ff;
   logic [ACC_W-1:0]   rspData_ff;
   logic               rspSkip_ff;
   logic [IOT_W-1:0]   opCode;
   logic               cntZero;
   logic               settled;
   logic               released;

   assign opCode = (reqOp == OP_SELECT)  ? IOT_CHAN_SELECT :
                   (reqOp == OP_INDEX)   ? IOT_CHAN_INDEX :
                   (reqOp == OP_CONVERT) ? IOT_SEL_CONVERT :
                   (reqOp == OP_READ)    ? IOT_READ_BUF : IOT_FLAG_TEST;
   assign clk_w    = bus.clk;
   assign cntZero  = cnt_ff == '0;
   assign settled  = settle_ff >= CNT_W'(MUX_SETTLE_CYC); // [R17]
   assign released = release_ff >= CNT_W'(ADDR_RELEASE_CYC); // [R20]

   always_ff @(posedge clk_w) begin
      if (bus.srst) begin
         state_ff <= H_IDLE;
         cnt_ff <= '0;
         settle_ff <= CNT_W'(MUX_SETTLE_CYC);
         release_ff <= CNT_W'(ADDR_RELEASE_CYC);
         strobe_ff <= 1'b0;
         code_ff <= '0;
         acc_ff <= '0;
         addrN_ff <= '1;
         {clear_ff, readin_ff, index_ff, conv_ff} <= '0;
         ready_ff <= 1'b1;
         rspValid_ff <= 1'b0;
         rspData_ff <= '0;
         rspSkip_ff <= 1'b0;
      end else begin
         rspValid_ff <= 1'b0;
         strobe_ff <= 1'b0;
         cnt_ff <= cntZero ? cnt_ff : cnt_ff - CNT_W'(1);
         if (!settled) settle_ff <= settle_ff + CNT_W'(1);
         if (!released && addrN_ff == '1) release_ff <= release_ff + CNT_W'(1);
         case (state_ff)
            H_IDLE: begin
               if (reqValid) begin
                  ready_ff <= 1'b0;
                  if (reqOp == OP_PIN_LOAD) begin
                     addrN_ff <= ~reqData[CHAN_W-1:0];
                     release_ff <= '0;
                     cnt_ff <= CNT_W'(ADDR_SETUP_CYC); // [R19]
                     state_ff <= H_SETUP;
                  end else if (reqOp == OP_PIN_INDEX) begin
                     state_ff <= H_RELEASE;
                  end else if (reqOp == OP_PIN_CONVERT) begin
                     state_ff <= H_SETTLE;
                  end else begin
                     strobe_ff <= 1'b1;
                     code_ff <= opCode;
                     acc_ff <= reqData;
                     state_ff <= H_IOT;
                  end
               end
            end
            H_IOT: state_ff <= H_ANS;
            H_ANS: begin
               rspValid_ff <= 1'b1;
               rspData_ff <= bus.accValid ? bus.accFromDev : '0;
               rspSkip_ff <= bus.skipReq;
               ready_ff <= 1'b1;
               state_ff <= H_IDLE;
            end
            H_SETUP: if (cntZero) begin
               clear_ff <= 1'b1;
               settle_ff <= '0;
               cnt_ff <= CNT_W'(PIN_PULSE_CYC);
               state_ff <= H_CLEAR;
            end
            H_CLEAR: if (cntZero) begin
               clear_ff <= 1'b0;
               cnt_ff <= CNT_W'(READIN_DELAY_CYC - PIN_PULSE_CYC); // [R18]
               state_ff <= H_GAP;
            end
            H_GAP: if (cntZero) begin
               readin_ff <= 1'b1;
               cnt_ff <= CNT_W'(PIN_PULSE_CYC);
               state_ff <= H_READIN;
            end
            H_READIN: if (cntZero) begin
               readin_ff <= 1'b0;
               addrN_ff <= '1;
               rspValid_ff <= 1'b1;
               ready_ff <= 1'b1;
               state_ff <= H_IDLE;
            end
            H_RELEASE: if (released) begin // [R20]
               index_ff <= 1'b1;
               settle_ff <= '0;
               cnt_ff <= CNT_W'(PIN_PULSE_CYC);
               state_ff <= H_INDEX;
            end
            H_INDEX: if (cntZero) begin
               index_ff <= 1'b0;
               rspValid_ff <= 1'b1;
               ready_ff <= 1'b1;
               state_ff <= H_IDLE;
            end
            H_SETTLE: if (settled) begin // [R17]
               conv_ff <= 1'b1;
               cnt_ff <= CNT_W'(CONV_PULSE_CYC);
               state_ff <= H_CONVERT;
            end
            H_CONVERT: if (cntZero) begin
               conv_ff <= 1'b0;
               rspValid_ff <= 1'b1;
               ready_ff <= 1'b1;
               state_ff <= H_IDLE;
            end
            default: state_ff <= H_IDLE;
         endcase
      end
   end

   assign bus.iotStrobe  = strobe_ff;
   assign bus.iotCode    = code_ff;
   assign bus.accToDev   = acc_ff;
   assign bus.addrLineN  = addrN_ff;
   assign bus.pinClear   = clear_ff;
   assign bus.pinReadin  = readin_ff;
   assign bus.pinIndex   = index_ff;
   assign bus.pinConvert = conv_ff;
   assign reqReady       = ready_ff;
   assign rspValid       = rspValid_ff;
   assign rspData        = rspData_ff;
   assign rspSkip        = rspSkip_ff;
endmodule
`default_nettype wire

/* verification/adc_mux_sva.sv */
// assertions on the transfer bus between host and device ends
`timescale 1ns/10ps
`default_nettype none
module adc_mux_sva (
   // bus
   input wire logic                           clk,
   input wire logic                           srst,
   input wire logic                           iotStrobe,
   input wire logic [adc_mux_pkg::IOT_W-1:0] iotCode,
   input wire logic [adc_mux_pkg::ACC_W-1:0] accFromDev,
   input wire logic                           accValid,
   input wire logic                           skipReq,
   input wire logic                           intReq,
   input wire logic                           pinIndex
);
   import adc_mux_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire rd = iotStrobe && iotCode == IOT_READ_BUF;
   wire cv = iotStrobe && iotCode == IOT_SEL_CONVERT;
   wire ft = iotStrobe && iotCode == IOT_FLAG_TEST;
   wire ld = iotStrobe && (iotCode == IOT_CHAN_SELECT || iotCode == IOT_CHAN_INDEX);
   ////////////////////////////////////////////////////////////////
   a_read_answer: assert property (rd |=> accValid && accFromDev[6:0] == 7'h00)
      else $error("read got no answer");
   a_read_clears: assert property (rd && intReq |=> !intReq)
      else $error("read left flag set");
   a_convert_clears: assert property (cv && intReq |=> !intReq)
      else $error("convert left flag set");
   a_convert_finish: assert property (cv |-> ##[2:60] intReq)
      else $error("conversion never finished");
   a_skip_set: assert property (ft && intReq |=> skipReq)
      else $error("no skip with flag set");
   a_skip_clear: assert property (ft && !intReq |=> !skipReq)
      else $error("skip with flag clear");
   a_skip_cause: assert property (skipReq |-> $past(ft))
      else $error("skip without test");
   a_select_no_start: assert property (ld && intReq |=> intReq)
      else $error("channel load touched flag");
   a_buffer_holds: assert property (!accValid |-> $stable(accFromDev))
      else $error("read data moved");
   c_read: cover property (rd && intReq);
   c_skip: cover property (ft && intReq);
   c_conv: cover property (cv);
   c_pin_index: cover property ($rose(pinIndex));
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench: host and device ends joined by the bus
`timescale 1ns/10ps
`default_nettype none
module tb;
   import adc_mux_pkg::*;
   logic                clk = 1'b0;
   logic                srst = 1'b1;
   logic                reqValid = 1'b0;
   host_op_e            reqOp = OP_TEST;
   logic [ACC_W-1:0]    reqData = '0;
   logic                reqReady, rspValid, rspSkip, convBusy, convFlag;
   logic [ACC_W-1:0]    rspData;
   logic [WLEN_W-1:0]   wlen = 4'hB;
   logic [ACCSEL_W-1:0] acc = 2'h0;
   logic [CHAN_W-1:0]   scanLast = 6'h3F, muxChannel;
   logic [RES_W-1:0]    level = '0, resultBuf;
   int                  err_total = 0, n_compared = 0, cyc = 0, busyCyc = 0;
   logic [ACC_W-1:0]    ex [4] = '{18'h20000, 18'h00000, 18'h1FF80, 18'h1F000};
   logic [WLEN_W-1:0]   wl [4] = '{4'hB, 4'hB, 4'hB, 4'h6};
   logic [ACCSEL_W-1:0] ac [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
   logic [RES_W-1:0]    lv [4] = '{11'h000, 11'h400, 11'h7FF, 11'h7FF};
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   adc_mux_if u_adc_mux_if (.clk(clk), .srst(srst));
   adc_mux_host u_adc_mux_host (.bus(u_adc_mux_if), .reqValid(reqValid), .reqOp(reqOp),
      .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .rspSkip(rspSkip));
   adc_mux_device #(.CHANNELS(64), .CONV_SCALE_NS(10)) u_adc_mux_device (
      .bus(u_adc_mux_if), .panelWordLen(wlen), .panelAccuracy(acc),
      .panelScanLast(scanLast), .sampleLevel(level), .muxChannel(muxChannel),
      .convBusy(convBusy), .convFlag(convFlag), .resultBuf(resultBuf));
   adc_mux_sva u_adc_mux_sva (.clk(clk), .srst(srst), .iotStrobe(u_adc_mux_if.iotStrobe),
      .iotCode(u_adc_mux_if.iotCode), .accFromDev(u_adc_mux_if.accFromDev),
      .accValid(u_adc_mux_if.accValid), .skipReq(u_adc_mux_if.skipReq),
      .intReq(u_adc_mux_if.intReq), .pinIndex(u_adc_mux_if.pinIndex));
   ////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one user request, returns at the negedge showing the answer
   task automatic op(input host_op_e o, input logic [ACC_W-1:0] d = '0);
      int n;
      n = 0;
      @(negedge clk);
      while (reqReady !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      reqOp = o;
      reqData = d;
      reqValid = 1'b1;
      @(negedge clk);
      reqValid = 1'b0;
      while (rspValid !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000)
         chk(18'h0, 18'h1);
   endtask
   task automatic wait_flag;
      for (int n = 0; n < 200 && convFlag !== 1'b1; n++)
         @(negedge clk);
      chk(18'(convFlag), 18'h1);
   endtask
   always @(negedge clk) if (convBusy === 1'b1) busyCyc++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      int us;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      repeat (6) @(negedge clk);
      op(OP_SELECT, 18'h3FF3F);
      chk(18'(muxChannel), 18'h3F);
      chk(18'(convBusy), 18'h0);
      op(OP_INDEX);
      chk(18'(muxChannel), 18'h0);
      scanLast = 6'h07;
      op(OP_SELECT, 18'h7);
      op(OP_INDEX);
      chk(18'(muxChannel), 18'h0);
      scanLast = 6'h3F;
      op(OP_PIN_LOAD, 18'h2A);
      chk(18'(muxChannel), 18'h2A);
      op(OP_PIN_INDEX);
      chk(18'(muxChannel), 18'h2B);
      chk(18'(convBusy), 18'h0);
      $display("test channel done");
      for (int i = 0; i < 4; i++) begin
         level = lv[i];
         wlen = wl[i];
         acc = ac[i];
         us = CONV_US[ac[i]][wl[i] - 6];
         repeat (6) @(negedge clk);
         busyCyc = 0;
         op(OP_CONVERT);
         wait_flag();
         chk(18'(busyCyc inside {[us:us + 1]}), 18'h1);
         level = ~level;
         op(OP_TEST);
         chk(18'(rspSkip), 18'h1);
         op(OP_READ);
         chk(rspData, ex[i]);
         chk(18'(resultBuf), ex[i] >> 7);
         chk(18'(convFlag), 18'h0);
         op(OP_TEST);
         chk(18'(rspSkip), 18'h0);
      end
      $display("test convert done");
      op(OP_PIN_CONVERT);
      wait_flag();
      op(OP_CONVERT);
      chk(18'(convFlag), 18'h0);
      wait_flag();
      op(OP_INDEX);
      chk(18'(convFlag), 18'h1);
      chk(18'(convBusy), 18'h0);
      $display("test pin convert done");
      summarize();
   end
endmodule
`default_nettype wire
